// File: byte_timer.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module byte_timer
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // register port
  input wire logic [byte_timer_pkg::AW-1:0] i_addr,
  input wire logic [byte_timer_pkg::DW-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [byte_timer_pkg::DW-1:0] o_rd_data,
  // timer pin and interrupt
  output logic o_byte_timer_output,
  output logic o_irq
);
  import byte_timer_pkg::*;

  // =====================================================================
  // state and decode
  state_s st; // registered state
  state_s next_st; // next state
  logic wr_ctrl; // control write
  logic wr_shared; // shared control write
  logic wr_rlo; // low reload write
  logic wr_rhi; // high reload write
  logic wr_status; // status write
  logic wr_mask; // mask write
  logic [2:0] div_mask; // prescaler mask
  logic tick; // prescaled timer clock
  logic terminal; // count reaching zero
  logic start; // enable while stopped
  logic set_to; // timeout event
  logic clr_to; // software clear

  // address decode of writes
  always_comb
  begin
    wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    wr_shared = i_wr && (i_addr == ADDR_SHARED);
    wr_rlo = i_wr && (i_addr == ADDR_RLO);
    wr_rhi = i_wr && (i_addr == ADDR_RHI);
    wr_status = i_wr && (i_addr == ADDR_STATUS);
    wr_mask = i_wr && (i_addr == ADDR_MASK);
  end

  // =====================================================================
  // prescaler select
  always_comb
  begin
    case (st.clksel)
      2'h0: div_mask = DIV1_MASK;
      2'h1: div_mask = DIV2_MASK;
      2'h2: div_mask = DIV4_MASK;
      default: div_mask = DIV8_MASK;
    endcase
  end

  // tick when the masked prescaler bits are all ones
  assign tick = ((st.presc & div_mask) == div_mask);
  assign terminal = st.running && tick && (st.count == TERM_COUNT);
  assign start = wr_ctrl && i_wr_data[CTRL_EN_BIT] && !st.running;
  assign clr_to = (wr_ctrl && i_wr_data[CTRL_FLAG_BIT]) || (wr_status && i_wr_data[STATUS_TO_BIT]);

  // =====================================================================
  // next state
  always_comb
  begin
    next_st = st;
    set_to = 1'b0;
    next_st.rd_data = 8'h00;
    next_st.presc = st.presc + 3'h1;
    // configuration writes
    if (wr_ctrl)
    begin
      next_st.mode_single = i_wr_data[CTRL_MODE_BIT];
      next_st.clksel = i_wr_data[CTRL_SEL_LSB +: 2];
      next_st.ie = i_wr_data[CTRL_IE_BIT];
    end
    if (wr_shared)
    begin
      next_st.init_level = i_wr_data[SHARED_INIT_BIT];
    end
    if (wr_rlo)
    begin
      next_st.reload_low_value = i_wr_data;
    end
    if (wr_rhi)
    begin
      next_st.reload_high_value = i_wr_data;
    end
    if (wr_mask)
    begin
      next_st.mask = i_wr_data[STATUS_TO_BIT];
    end
    // counting while running
    if (st.running && tick)
    begin
      if (st.count == TERM_COUNT)
      begin
        next_st.out_level = ~st.out_level;
        if (st.mode_single)
        begin
          // single pass ends at zero
          next_st.count = st.count - 8'h01;
          next_st.running = 1'b0;
          next_st.phase = PH_IDLE;
          set_to = 1'b1;
        end
        else
        begin
          // reload by the new level
          next_st.count = st.out_level ? st.reload_low_value : st.reload_high_value;
          case (st.phase)
            PH_FIRST:
            begin
              next_st.phase = PH_SECOND;
            end
            default:
            begin
              next_st.phase = PH_FIRST;
              set_to = 1'b1;
            end
          endcase
        end
      end
      else
      begin
        // zero wraps to FFh without timeout
        next_st.count = st.count - 8'h01;
      end
    end
    // start and stop
    if (start)
    begin
      next_st.running = 1'b1;
      next_st.phase = PH_FIRST;
      next_st.out_level = st.init_level;
      next_st.count = st.init_level ? st.reload_high_value : st.reload_low_value;
      next_st.presc = 3'h0;
    end
    else if (wr_ctrl && !i_wr_data[CTRL_EN_BIT])
    begin
      next_st.running = 1'b0;
      next_st.phase = PH_IDLE;
    end
    // timeout flag, a set beats a clear
    if (clr_to)
    begin
      next_st.flag = 1'b0;
    end
    if (set_to)
    begin
      next_st.flag = 1'b1;
    end
    // interrupt level
    next_st.irq = next_st.flag && next_st.ie && next_st.mask;
    // read data for the next cycle only
    if (i_rd)
    begin
      if (i_addr == ADDR_CTRL)
      begin
        next_st.rd_data = {st.running, st.mode_single, st.flag, st.clksel, 1'b0, st.ie, 1'b0};
      end
      else if (i_addr == ADDR_SHARED)
      begin
        next_st.rd_data = {6'h00, st.init_level, 1'b0};
      end
      else if (i_addr == ADDR_RLO)
      begin
        next_st.rd_data = st.reload_low_value;
      end
      else if (i_addr == ADDR_RHI)
      begin
        next_st.rd_data = st.reload_high_value;
      end
      else if (i_addr == ADDR_COUNT)
      begin
        next_st.rd_data = st.count;
      end
      else if (i_addr == ADDR_STATUS)
      begin
        next_st.rd_data = {7'h00, st.flag};
      end
      else if (i_addr == ADDR_MASK)
      begin
        next_st.rd_data = {7'h00, st.mask};
      end
      else
      begin
        next_st.rd_data = 8'h00;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      st <= STATE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign o_rd_data = st.rd_data;
  assign o_byte_timer_output = st.out_level;
  assign o_irq = st.irq;

  // =====================================================================
  // assertions
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  // output takes initial level on start
  AST_START_LEVEL: assert property (start |=> o_byte_timer_output == $past(st.init_level))
    else $error("output not at initial level after enable");

  // counter loaded by initial level
  AST_START_LOAD: assert property (start |=>
    st.count == ($past(st.init_level) ? $past(st.reload_high_value) : $past(st.reload_low_value)))
    else $error("wrong reload on enable");

  // single pass halts with flag and toggle
  AST_SINGLE_STOP: assert property ((terminal && st.mode_single && !wr_ctrl) |=>
    !st.running && st.flag && st.count == 8'h00 && o_byte_timer_output != $past(o_byte_timer_output))
    else $error("single pass did not stop correctly");

  // interrupt follows flag and enable
  AST_IRQ: assert property (o_irq |-> st.flag && st.ie && st.mask)
    else $error("interrupt without enabled flag");

  AST_IRQ_RISE: assert property ((st.flag && st.ie && st.mask && !clr_to && !wr_ctrl && !wr_mask) |=> o_irq)
    else $error("interrupt missing");

  // first terminal in repeat mode sets no flag; a stop write in that cycle may halt it
  AST_FIRST_NOFLAG: assert property ((terminal && !st.mode_single && st.phase == PH_FIRST && !st.flag &&
    !wr_ctrl) |=>
    !st.flag && st.running && o_byte_timer_output != $past(o_byte_timer_output))
    else $error("first terminal count set the flag");

  // reload by new level
  AST_RELOAD: assert property ((terminal && !st.mode_single && !wr_ctrl) |=>
    st.count == (o_byte_timer_output ? $past(st.reload_high_value) : $past(st.reload_low_value)))
    else $error("wrong reload after toggle");

  // second terminal sets flag
  // a stop write in the same cycle leaves the phase idle
  AST_SECOND_FLAG: assert property ((terminal && !st.mode_single && st.phase == PH_SECOND) |=>
    st.flag && (st.phase == PH_FIRST || !st.running))
    else $error("second terminal count missed the flag");

  // repeat mode keeps running
  AST_REPEAT_RUNS: assert property ((terminal && !st.mode_single && !wr_ctrl) |=> st.running)
    else $error("repeat mode stopped by itself");

  // write one clears the flag unless an event lands
  AST_CLEAR: assert property ((clr_to && !set_to) |=> !st.flag)
    else $error("flag not cleared");

  // wrap is not a timeout
  AST_WRAP: assert property ((st.running && tick && st.count == 8'h00 && !wr_ctrl && !st.flag) |=>
    st.count == WRAP_COUNT && !st.flag)
    else $error("zero did not wrap cleanly");

  // divide by eight gives seven idle cycles while the select stays at eight
  AST_DIV8: assert property ((tick && st.clksel == 2'h3 && !i_wr) |=>
    (!tick || st.clksel != 2'h3) [*7])
    else $error("prescaler by eight wrong");

  // stopped counter holds
  AST_HOLD: assert property ((!st.running && !start) |=> $stable(st.count))
    else $error("counter moved while stopped");

  // each tick away from terminal takes one off the count
  AST_DECREMENT: assert property ((st.running && tick && st.count != TERM_COUNT && !wr_ctrl) |=>
    st.count == $past(st.count) - 8'h01)
    else $error("counter did not step down on a tick");

  // read data only in the cycle after a read
  AST_RD_IDLE: assert property (!i_rd |=> o_rd_data == 8'h00)
    else $error("read data outside read slot");

  // main scenarios
  COV_SINGLE: cover property (start ##[1:300] (terminal && st.mode_single));
  COV_REPEAT: cover property ((terminal && st.phase == PH_SECOND) ##[1:300] terminal);
  COV_IRQ: cover property ($rose(o_irq));
  COV_WRAP: cover property (st.running && tick && st.count == 8'h00);
  // first toggle of a repeating run
  COV_FIRST_TOGGLE: cover property (terminal && !st.mode_single && st.phase == PH_FIRST);
endmodule

// File: byte_timer_pkg.sv
// =====================================================================
// constants and types shared by the byte timer
package byte_timer_pkg;
  // bus widths
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  // register indices; byte address is four times the index
  localparam logic [AW-1:0] IDX_CTRL = 8'h00;
  localparam logic [AW-1:0] IDX_SHARED = 8'h01;
  localparam logic [AW-1:0] IDX_RLO = 8'h02;
  localparam logic [AW-1:0] IDX_RHI = 8'h03;
  localparam logic [AW-1:0] IDX_COUNT = 8'h04;
  localparam logic [AW-1:0] IDX_STATUS = 8'h05;
  localparam logic [AW-1:0] IDX_MASK = 8'h06;
  localparam logic [AW-1:0] ADDR_CTRL = IDX_CTRL << 2;
  localparam logic [AW-1:0] ADDR_SHARED = IDX_SHARED << 2;
  localparam logic [AW-1:0] ADDR_RLO = IDX_RLO << 2;
  localparam logic [AW-1:0] ADDR_RHI = IDX_RHI << 2;
  localparam logic [AW-1:0] ADDR_COUNT = IDX_COUNT << 2;
  localparam logic [AW-1:0] ADDR_STATUS = IDX_STATUS << 2;
  localparam logic [AW-1:0] ADDR_MASK = IDX_MASK << 2;
  // field positions
  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned CTRL_MODE_BIT = 6;
  localparam int unsigned CTRL_FLAG_BIT = 5;
  localparam int unsigned CTRL_SEL_LSB = 3;
  localparam int unsigned CTRL_IE_BIT = 1;
  localparam int unsigned SHARED_INIT_BIT = 1;
  localparam int unsigned STATUS_TO_BIT = 0;
  // counter values
  localparam logic [DW-1:0] TERM_COUNT = 8'h01;
  localparam logic [DW-1:0] WRAP_COUNT = 8'hFF;
  localparam logic [DW-1:0] RELOAD_RST = 8'h00;
  localparam logic MASK_RST = 1'b1;
  // prescaler division masks for select codes 00..11
  localparam logic [2:0] DIV1_MASK = 3'h0;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;
  // half-cycle phase, gray coded
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_FIRST = 2'b01,
    PH_SECOND = 2'b11
  } phase_e;
  // whole state of the timer
  typedef struct packed {
    logic running;
    phase_e phase;
    logic [DW-1:0] count;
    logic out_level;
    logic flag;
    logic ie;
    logic mode_single;
    logic [1:0] clksel;
    logic init_level;
    logic [DW-1:0] reload_low_value;
    logic [DW-1:0] reload_high_value;
    logic mask;
    logic [2:0] presc;
    logic irq;
    logic [DW-1:0] rd_data;
  } state_s;
  localparam state_s STATE_RST = '{running: 1'b0, phase: PH_IDLE, count: RELOAD_RST, out_level: 1'b0,
    flag: 1'b0, ie: 1'b0, mode_single: 1'b0, clksel: 2'h0, init_level: 1'b0,
    reload_low_value: RELOAD_RST, reload_high_value: RELOAD_RST, mask: MASK_RST,
    presc: 3'h0, irq: 1'b0, rd_data: 8'h00};
endpackage

// File: byte_timer_dummy_unused.sv
`timescale 1ns/100ps

// File: byte_timer_tb.sv
`timescale 1ns/100ps
module testbench;
  import byte_timer_pkg::*;
  // ==========================================
  // stimulus, outputs and counters
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [AW-1:0] i_addr = '0;
  logic [DW-1:0] i_wr_data = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DW-1:0] o_rd_data;
  logic o_byte_timer_output;
  logic o_irq;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h576d;
  logic [DW-1:0] ctl; // control value of the current run
  // reference model state
  logic e_run, e_single, e_ie, e_init, e_mask, e_out, e_flag, e_second, e_irq, e_was_run;
  logic e_armed = 1'b0;
  logic [1:0] e_sel;
  logic [2:0] e_presc;
  logic [DW-1:0] e_cnt, e_rlo, e_rhi, e_dat;
  // 50 ns clock
  always #25 i_core_clk = ~i_core_clk;
  byte_timer DUT (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_byte_timer_output(o_byte_timer_output), .o_irq(o_irq));
  // ==========================================
  // comparison and bus tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {i_addr, i_wr_data, i_wr, i_rd} <= {a, d, 2'b10};
    @(posedge i_core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    {i_addr, i_wr, i_rd} <= {a, 2'b01};
    @(posedge i_core_clk);
  endtask
  task automatic idle();
    {i_wr, i_rd} <= 2'b00;
    @(posedge i_core_clk);
  endtask
  // random reload value, never the unsupported 1
  function automatic logic [7:0] pick();
    return 8'(2 + {$random(seed)} % 8);
  endfunction
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // reference model, outputs compared every cycle
  always @(posedge i_core_clk)
  begin
    if (e_armed)
    begin
      check({7'h00, o_byte_timer_output}, {7'h00, e_out});
      check({7'h00, o_irq}, {7'h00, e_irq});
      check(o_rd_data, e_dat);
    end
    e_armed = 1'b1;
    if (i_srst)
    begin
      {e_run, e_single, e_ie, e_init, e_out, e_flag, e_second, e_irq, e_sel, e_presc} = '0;
      {e_cnt, e_rlo, e_rhi, e_dat} = '0;
      e_mask = 1'b1;
    end
    else
    begin
      e_dat = 8'h00;
      if (i_rd)
        case (i_addr)
          ADDR_CTRL: e_dat = {e_run, e_single, e_flag, e_sel, 1'b0, e_ie, 1'b0};
          ADDR_SHARED: e_dat = {6'h00, e_init, 1'b0};
          ADDR_RLO: e_dat = e_rlo;
          ADDR_RHI: e_dat = e_rhi;
          ADDR_COUNT: e_dat = e_cnt;
          ADDR_STATUS: e_dat = {7'h00, e_flag};
          ADDR_MASK: e_dat = {7'h00, e_mask};
          default: e_dat = 8'h00;
        endcase
      // clear before the tick so a same-cycle timeout wins
      if (i_wr && ((i_addr == ADDR_STATUS && i_wr_data[0]) || (i_addr == ADDR_CTRL && i_wr_data[5])))
        e_flag = 1'b0;
      e_was_run = e_run;
      // prescaled tick
      if (e_run && (e_presc % (1 << e_sel)) == (1 << e_sel) - 1)
      begin
        if (e_cnt == 8'h01)
        begin
          e_out = ~e_out;
          if (e_single)
          begin
            e_cnt = 8'h00;
            e_run = 1'b0;
            e_flag = 1'b1;
          end
          else
          begin
            e_cnt = e_out ? e_rhi : e_rlo;
            e_flag = e_flag | e_second;
            e_second = ~e_second;
          end
        end
        else
          e_cnt = e_cnt - 8'h01;
      end
      if (e_run)
        e_presc = e_presc + 3'h1;
      // register writes land after the tick
      if (i_wr)
        case (i_addr)
          ADDR_CTRL:
          begin
            {e_single, e_sel, e_ie} = {i_wr_data[6], i_wr_data[4:3], i_wr_data[1]};
            if (!i_wr_data[7])
              e_run = 1'b0;
            else if (!e_was_run)
            begin
              {e_run, e_out, e_presc, e_second} = {1'b1, e_init, 3'h0, 1'b0};
              e_cnt = e_init ? e_rhi : e_rlo;
            end
          end
          ADDR_SHARED: e_init = i_wr_data[1];
          ADDR_RLO: e_rlo = i_wr_data;
          ADDR_RHI: e_rhi = i_wr_data;
          ADDR_MASK: e_mask = i_wr_data[0];
          default: ;
        endcase
      // interrupt level follows the updated flag, enable and mask in the same cycle
      e_irq = e_flag & e_ie & e_mask;
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    i_srst <= 1'b0;
    idle();
    // reset values, unmapped and misaligned places
    for (int a = 0; a < 8; a++)
      rd(8'(a * 4));
    rd(8'h01);
    wr(8'h1C, 8'hFF);
    rd(8'h1C);
    // every mode, select code, level, enable and mask
    for (int k = 0; k < 16; k++)
    begin
      wr(ADDR_RLO, (k == 9) ? 8'h00 : pick());
      wr(ADDR_RHI, (k == 9) ? 8'h00 : pick());
      wr(ADDR_SHARED, {6'h00, k[0], 1'b0});
      wr(ADDR_MASK, {7'h00, k != 5});
      ctl = {1'b1, k[1], 1'b0, k[3:2], 1'b0, k != 6, 1'b0};
      wr(ADDR_CTRL, ctl);
      for (int c = 0; c < 300; c++)
        if (c == 40)
          wr(ADDR_CTRL, ctl);
        else if ($random(seed) % 4 == 0)
          rd(8'({$random(seed)} % 8 * 4));
        else
          idle();
      wr(ADDR_CTRL, ctl & 8'h7F);
      rd(ADDR_COUNT);
      idle();
      rd(ADDR_COUNT);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS);
      if (k[0])
        wr(ADDR_STATUS, 8'h01);
      else
        wr(ADDR_CTRL, 8'h20);
      rd(ADDR_CTRL);
    end
    idle();
    give_verdict();
  end
  // watchdog, well past the expected run length
  initial
  begin
    #1000000;
    miscompares++;
    give_verdict();
  end
endmodule
